// >>> design/ptspi_pkg.sv
// Purpose: shared constants for the pressure/temperature serial readout link
// Assumes: system clock of 125 MHz on both ends' user side
// Notes:   times are kept in ns; cycle counts derive from them
package ptspi_pkg;

    // ==========================================================
    // clock rates
    localparam int SYS_CLK_MHZ  = 125;
    localparam int OSC_HZ_FAST  = 4000000;  // factory oscillator
    localparam int OSC_HZ_SLOW  = 1000000;

    // ==========================================================
    // link timing, ns
    localparam int T_HDSS_NS    = 2500;     // select low to first edge
    localparam int T_PHASE_NS   = 600;      // least low or high width
    localparam int T_CLKD_NS    = 100;      // edge to new data, most
    localparam int T_SUSS_NS    = 100;      // last edge to select high
    localparam int T_BUS_NS     = 2000;     // idle between frames

    // ==========================================================
    // clock frequency limits, kHz
    localparam int SCLK_MIN_KHZ      = 50;
    localparam int SCLK_MAX_KHZ_FAST = 800;
    localparam int SCLK_MAX_KHZ_SLOW = 200;
    localparam int SCLK_DEF_KHZ      = 400;

    // ==========================================================
    // least times round up to whole system cycles
    localparam int HDSS_CYC  = (T_HDSS_NS * SYS_CLK_MHZ + 999) / 1000;
    localparam int PHASE_CYC = (T_PHASE_NS * SYS_CLK_MHZ + 999) / 1000;
    localparam int SUSS_CYC  = (T_SUSS_NS * SYS_CLK_MHZ + 999) / 1000;
    localparam int BUS_CYC   = (T_BUS_NS * SYS_CLK_MHZ + 999) / 1000;

    // ==========================================================
    // packet layout
    localparam int PKT_BITS    = 32;
    localparam int PRESS_W     = 14;
    localparam int TEMP_W      = 11;
    localparam int PRESS_LSB   = 16;        // bits 29:16, 31:30 read zero
    localparam int TEMP_LSB    = 5;         // bits 15:5, 4:0 undefined
    localparam logic [15:0] PRESS_MAX = 16'h3FFF;
    localparam logic [15:0] TEMP_MAX  = 16'h07FF;

endpackage : ptspi_pkg

// >>> design/ptspi_if.sv
// Purpose: the three-wire read-only serial link between sensor and master
// Assumes: a weak pull-up holds the data line when nobody drives it
// Notes:   the data line level is resolved here from the enable
`timescale 1ns/10ps
`default_nettype none

interface ptspi_if;
    logic ss_n;         // select, active low, from master
    logic sclk;         // link clock, idles high, from master
    logic miso;         // sensor data out
    logic miso_oe;      // sensor drives the line while high
    logic miso_line;    // resolved wire level

    // pull-up stands in for the undriven line
    assign miso_line = miso_oe ? miso : 1'b1;

    modport sensor (input ss_n, input sclk, output miso, output miso_oe);
    modport master (output ss_n, output sclk, input miso_line);
endinterface : ptspi_if

`default_nettype wire

// >>> design/ptspi_sensor.sv
// Purpose: sensor end of the read-only serial link; shifts out results
// Assumes: results arrive on the system clock with a valid strobe
// Notes:   the shifter runs on the link clock, which stops between frames
//
// Contract
// - transmit only; no bits taken from master
// - falling edge launch, 4 MHz oscillator default
// - data changes only after falling clock edge
// - master samples data on rising clock edge
// - thirty-two bits, most significant bit first
// - bytes one, two carry 14-bit pressure
// - bytes three, four carry 11-bit temperature
// - master masks five undefined low bits
// - frame may end after two bytes
// - frame may end after three bytes
// - fast oscillator: clock 50 to 800 kHz
// - slow oscillator: clock 50 to 200 kHz
// - 2.5 us from select low to edge
// - clock low and high 0.6 us each
// - new bit within 0.1 us of edge
// - select rises 0.1 us after last edge
// - 2 us idle between frames
// - pressure code 0 to 16383, linear
// - temperature code 0 to 2047, linear
`timescale 1ns/10ps
`default_nettype none

module ptspi_sensor #(
    parameter int OSC_HZ   = ptspi_pkg::OSC_HZ_FAST,
    parameter bit NEG_EDGE = 1'b1
) (
    input  wire logic        I_CLK_SYS,
    input  wire logic        I_NRST,
    ptspi_if.sensor          link,
    input  wire logic [15:0] I_PRESS,
    input  wire logic [15:0] I_TEMP,
    input  wire logic        I_VALID,
    output logic             O_BUSY,
    output logic             O_FRESH,
    output logic [15:0]      O_FRAMES
);

    // ==========================================================
    // helpers

    // saturate a code to its full-scale value; linear scale is upstream
    function automatic logic [15:0] sat(input logic [15:0] v,
                                        input logic [15:0] top);
        sat = (v > top) ? top : v;
    endfunction : sat

    // ==========================================================
    // declarations
    logic        ss_s1_q;
    logic        ss_s2_q;
    logic        ss_s3_q;
    logic        frame;
    logic        frame_end;
    logic [31:0] snap_q;
    logic        fresh_q;
    logic        oe_q;
    logic [15:0] frames_q;
    logic        link_rst;
    logic [5:0]  bit_cnt_q;
    logic [31:0] shift_q;
    logic        miso_q;
    logic [15:0] press_sat;
    logic [15:0] temp_sat;

    // ==========================================================
    // system domain: select synchroniser

    // two flops before use; the third only feeds the edge detector
    always_ff @(posedge I_CLK_SYS or negedge I_NRST)
    begin
        if (!I_NRST)
        begin
            ss_s1_q <= 1'b1;
            ss_s2_q <= 1'b1;
            ss_s3_q <= 1'b1;
        end
        else
        begin
            ss_s1_q <= link.ss_n;
            ss_s2_q <= ss_s1_q;
            ss_s3_q <= ss_s2_q;
        end
    end

    assign frame     = !ss_s2_q;
    assign frame_end = !ss_s2_q ? 1'b0 : !ss_s3_q;

    // ==========================================================
    // system domain: result snapshot

    // clamp to the documented full scale of each code
    assign press_sat = sat(I_PRESS, ptspi_pkg::PRESS_MAX);
    assign temp_sat  = sat(I_TEMP, ptspi_pkg::TEMP_MAX);

    // the snapshot is frozen while a frame runs, so the link side reads
    // a stable word; select low to first edge leaves ample settle time
    always_ff @(posedge I_CLK_SYS or negedge I_NRST)
    begin
        if (!I_NRST)
        begin
            snap_q <= 32'h0000_0000;
        end
        else if (I_VALID && !frame)
        begin
            snap_q <= {2'h0,
                       press_sat[ptspi_pkg::PRESS_W-1:0],
                       temp_sat[ptspi_pkg::TEMP_W-1:0],
                       5'h00};
        end
    end

    // fresh flag: set by a new sample, cleared by a frame; set wins
    always_ff @(posedge I_CLK_SYS or negedge I_NRST)
    begin
        if (!I_NRST)
        begin
            fresh_q <= 1'b0;
        end
        else if (I_VALID && !frame)
        begin
            fresh_q <= 1'b1;
        end
        else if (frame_end)
        begin
            fresh_q <= 1'b0;
        end
    end

    // ==========================================================
    // system domain: drive enable and frame count

    // enable follows select a few system cycles late, far inside the
    // lead time the master must leave before its first edge
    always_ff @(posedge I_CLK_SYS or negedge I_NRST)
    begin
        if (!I_NRST)
        begin
            oe_q <= 1'b0;
        end
        else
        begin
            oe_q <= frame;
        end
    end

    // every completed frame is counted, short ones included
    always_ff @(posedge I_CLK_SYS or negedge I_NRST)
    begin
        if (!I_NRST)
        begin
            frames_q <= 16'h0000;
        end
        else if (frame_end)
        begin
            frames_q <= frames_q + 16'h0001;
        end
    end

    assign O_BUSY   = oe_q;
    assign O_FRESH  = fresh_q;
    assign O_FRAMES = frames_q;

    // ==========================================================
    // link domain: output shifter

    // select high holds the shifter at its start, so any frame, whole or
    // cut short, restarts from the first bit
    assign link_rst = link.ss_n | !I_NRST;

    // bit counter; counts launched bits, stops after the last
    always_ff @(negedge link.sclk or posedge link_rst)
    begin
        if (link_rst)
        begin
            bit_cnt_q <= 6'h00;
        end
        else if (bit_cnt_q != 6'(ptspi_pkg::PKT_BITS))
        begin
            bit_cnt_q <= bit_cnt_q + 6'h01;
        end
    end

    // the first falling edge loads the snapshot and launches its top bit;
    // later falling edges shift, so the bit holds over the rising edge
    // the master samples on; only falling-edge polarity is built
    always_ff @(negedge link.sclk or posedge link_rst)
    begin
        if (link_rst)
        begin
            shift_q <= 32'h0000_0000;
            miso_q  <= 1'b0;
        end
        else if (bit_cnt_q == 6'h00)
        begin
            miso_q  <= snap_q[31];
            shift_q <= {snap_q[30:0], 1'b0};
        end
        else if (bit_cnt_q != 6'(ptspi_pkg::PKT_BITS))
        begin
            miso_q  <= shift_q[31];
            shift_q <= {shift_q[30:0], 1'b0};
        end
        else
        begin
            miso_q  <= 1'b0;
        end
    end

    // data leaves from a flop straight off the edge, well inside 0.1 us;
    // nothing is ever read from the master
    assign link.miso    = miso_q;
    assign link.miso_oe = oe_q;

endmodule : ptspi_sensor

`default_nettype wire

// >>> design/ptspi_master.sv
// Purpose: master end of the read-only serial link; reads one packet
// Assumes: system clock of 125 MHz; link clock made here by division
// Notes:   clock idles high, so the first edge of a frame is falling
`timescale 1ns/10ps
`default_nettype none

module ptspi_master #(
    parameter bit OSC_FAST = 1'b1,
    parameter int SCLK_KHZ = ptspi_pkg::SCLK_DEF_KHZ
) (
    input  wire logic        I_CLK_SYS,
    input  wire logic        I_NRST,
    ptspi_if.master          link,
    input  wire logic        I_START,
    input  wire logic [1:0]  I_NBYTES,
    output logic             O_BUSY,
    output logic             O_DONE,
    output logic [13:0]      O_PRESS,
    output logic [10:0]      O_TEMP
);

    // ==========================================================
    // clock rate: the request is clamped to the oscillator's limit
    localparam int MAX_KHZ  = OSC_FAST ? ptspi_pkg::SCLK_MAX_KHZ_FAST
                                       : ptspi_pkg::SCLK_MAX_KHZ_SLOW;
    localparam int KHZ_HI   = (SCLK_KHZ > MAX_KHZ) ? MAX_KHZ : SCLK_KHZ;
    localparam int KHZ      = (KHZ_HI < ptspi_pkg::SCLK_MIN_KHZ)
                              ? ptspi_pkg::SCLK_MIN_KHZ : KHZ_HI;
    localparam int HALF_RAW = (ptspi_pkg::SYS_CLK_MHZ * 500 + KHZ - 1) / KHZ;
    localparam int HALF_CYC = (HALF_RAW < ptspi_pkg::PHASE_CYC)
                              ? ptspi_pkg::PHASE_CYC : HALF_RAW;

    typedef enum logic [5:0] {
        ST_IDLE  = 6'h01,
        ST_SETUP = 6'h02,
        ST_LOW   = 6'h04,
        ST_HIGH  = 6'h08,
        ST_HOLD  = 6'h10,
        ST_GAP   = 6'h20
    } state_t;

    state_t      state_q;
    logic [11:0] tmr_q;
    logic [5:0]  cnt_q;
    logic [5:0]  nbits_q;
    logic [1:0]  nbytes_q;
    logic [31:0] sh_q;
    logic [31:0] pkt;
    logic        ss_n_q;
    logic        sclk_q;
    logic        done_q;
    logic        busy_q;
    logic        miso_s1_q;
    logic        miso_s2_q;
    logic [13:0] press_q;
    logic [10:0] temp_q;

    // ==========================================================
    // data input synchroniser
    always_ff @(posedge I_CLK_SYS or negedge I_NRST)
    begin
        if (!I_NRST)
        begin
            miso_s1_q <= 1'b1;
            miso_s2_q <= 1'b1;
        end
        else
        begin
            miso_s1_q <= link.miso_line;
            miso_s2_q <= miso_s1_q;
        end
    end

    // ==========================================================
    // frame sequencer and clock divider
    always_ff @(posedge I_CLK_SYS or negedge I_NRST)
    begin
        if (!I_NRST)
        begin
            state_q  <= ST_IDLE;
            tmr_q    <= 12'h000;
            cnt_q    <= 6'h00;
            nbits_q  <= 6'h20;
            nbytes_q <= 2'h0;
            sh_q     <= 32'h0000_0000;
            ss_n_q   <= 1'b1;
            sclk_q   <= 1'b1;
            busy_q   <= 1'b0;
        end
        else
        begin
            unique case (state_q)
                ST_IDLE:
                begin
                    if (I_START)
                    begin
                        ss_n_q   <= 1'b0;
                        busy_q   <= 1'b1;
                        tmr_q    <= 12'(ptspi_pkg::HDSS_CYC - 1);
                        cnt_q    <= 6'h00;
                        nbytes_q <= I_NBYTES;
                        // two or three bytes end early; anything else reads four
                        nbits_q  <= (I_NBYTES == 2'h2) ? 6'h10 :
                                    (I_NBYTES == 2'h3) ? 6'h18 :
                                    6'h20;
                        state_q  <= ST_SETUP;
                    end
                end
                ST_SETUP:
                begin
                    tmr_q <= tmr_q - 12'h001;
                    if (tmr_q == 12'h000)
                    begin
                        sclk_q  <= 1'b0;
                        tmr_q   <= 12'(HALF_CYC - 1);
                        state_q <= ST_LOW;
                    end
                end
                ST_LOW:
                begin
                    tmr_q <= tmr_q - 12'h001;
                    if (tmr_q == 12'h000)
                    begin
                        // sample on the rising edge we make now
                        sclk_q  <= 1'b1;
                        sh_q    <= {sh_q[30:0], miso_s2_q};
                        cnt_q   <= cnt_q + 6'h01;
                        tmr_q   <= 12'(HALF_CYC - 1);
                        state_q <= ST_HIGH;
                    end
                end
                ST_HIGH:
                begin
                    tmr_q <= tmr_q - 12'h001;
                    if (tmr_q == 12'h000)
                    begin
                        if (cnt_q == nbits_q)
                        begin
                            tmr_q   <= 12'(ptspi_pkg::SUSS_CYC - 1);
                            state_q <= ST_HOLD;
                        end
                        else
                        begin
                            sclk_q  <= 1'b0;
                            tmr_q   <= 12'(HALF_CYC - 1);
                            state_q <= ST_LOW;
                        end
                    end
                end
                ST_HOLD:
                begin
                    tmr_q <= tmr_q - 12'h001;
                    if (tmr_q == 12'h000)
                    begin
                        ss_n_q  <= 1'b1;
                        busy_q  <= 1'b0;
                        tmr_q   <= 12'(ptspi_pkg::BUS_CYC - 1);
                        state_q <= ST_GAP;
                    end
                end
                ST_GAP:
                begin
                    tmr_q <= tmr_q - 12'h001;
                    if (tmr_q == 12'h000)
                    begin
                        state_q <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // ==========================================================
    // results: left-justify what arrived, keep only defined bits
    assign pkt = sh_q << (6'h20 - cnt_q);

    always_ff @(posedge I_CLK_SYS or negedge I_NRST)
    begin
        if (!I_NRST)
        begin
            press_q <= 14'h0000;
            temp_q  <= 11'h000;
            done_q  <= 1'b0;
        end
        else
        begin
            done_q <= 1'b0;
            if (state_q == ST_HOLD && tmr_q == 12'h000)
            begin
                done_q  <= 1'b1;
                press_q <= pkt[ptspi_pkg::PRESS_LSB +: ptspi_pkg::PRESS_W];
                // low five bits of byte four are masked off
                if (nbytes_q == 2'h3)
                begin
                    temp_q <= {pkt[15:8], 3'h0};
                end
                else if (nbytes_q != 2'h2)
                begin
                    temp_q <= pkt[ptspi_pkg::TEMP_LSB +: ptspi_pkg::TEMP_W];
                end
            end
        end
    end

    assign link.ss_n = ss_n_q;
    assign link.sclk = sclk_q;
    assign O_BUSY    = busy_q;
    assign O_DONE    = done_q;
    assign O_PRESS   = press_q;
    assign O_TEMP    = temp_q;

endmodule : ptspi_master

`default_nettype wire

// >>> testbench/ptspi_checker.sv
// Purpose: watches the link between sensor and master on the system clock
// Assumes: select and link clock come from flops on I_CLK_SYS
// Notes:   link edges show as level changes between system samples
`timescale 1ns/10ps
`default_nettype none

module ptspi_checker (
    input wire logic I_CLK_SYS,
    input wire logic I_NRST,
    input wire logic ss_n,
    input wire logic sclk,
    input wire logic miso,
    input wire logic miso_oe,
    input wire logic miso_line
);
    localparam int MAX_HALF = 1250; // half period at 50 kHz
    logic        sclk_q;
    logic [11:0] ph_q;      // cycles since last clock change in a frame
    logic [11:0] id_q;      // cycles with select high
    logic [5:0]  bc_q;      // falling edges seen in this frame

    // ==========================================================
    // helper counters; idle starts full so a start after reset is legal
    always_ff @(posedge I_CLK_SYS or negedge I_NRST)
    begin
        if (!I_NRST)
        begin
            sclk_q <= 1'b1;
            ph_q   <= 12'h000;
            id_q   <= 12'hFFF;
            bc_q   <= 6'h00;
        end
        else
        begin
            sclk_q <= sclk;
            if (ss_n || sclk != sclk_q)
                ph_q <= 12'h000;
            else if (ph_q != 12'hFFF)
                ph_q <= ph_q + 12'h001;
            id_q   <= !ss_n ? 12'h000 : id_q + ((id_q != 12'hFFF) ? 12'h001 : 12'h000);
            bc_q   <= ss_n ? 6'h00 : bc_q + ((sclk_q && !sclk) ? 6'h01 : 6'h00);
        end
    end

    // ==========================================================
    // assertions
    default clocking cb @(posedge I_CLK_SYS); endclocking
    default disable iff (!I_NRST);

    sequence sel_high5;
        ss_n [*5];
    endsequence
    sequence sel_low5;
        !ss_n [*5];
    endsequence

    launch_on_fall_a: assert property (
        (!ss_n && !$past(ss_n) && $changed(miso)) |-> $fell(sclk))
        else $error("data changed away from a falling clock edge");
    drive_off_idle_a: assert property (sel_high5 |-> !miso_oe)
        else $error("data driven while not selected");
    drive_on_frame_a: assert property (sel_low5 |-> miso_oe)
        else $error("data not driven during a frame");
    select_hold_a: assert property (
        ($fell(sclk) && bc_q == 6'h00) |-> ph_q >= ptspi_pkg::HDSS_CYC - 2)
        else $error("first clock edge too soon after select");
    phase_width_a: assert property (
        ($changed(sclk) && !ss_n && !$past(ss_n)) |-> ph_q >= ptspi_pkg::PHASE_CYC - 1)
        else $error("clock phase too short");
    slow_limit_a: assert property (!ss_n |-> ph_q < MAX_HALF)
        else $error("clock phase too long");
    select_rise_a: assert property ($rose(ss_n) |-> ph_q >= ptspi_pkg::SUSS_CYC - 1)
        else $error("select rose too soon after last edge");
    bus_free_a: assert property ($fell(ss_n) |-> id_q >= ptspi_pkg::BUS_CYC - 1)
        else $error("bus free time too short");
    clock_idle_a: assert property (ss_n |-> sclk)
        else $error("link clock not high while idle");
    top_bits_zero_a: assert property (
        ($rose(sclk) && !ss_n && bc_q <= 6'd2) |-> !miso_line)
        else $error("unused top bit not zero");
    packet_len_a: assert property (!ss_n |-> bc_q <= 6'd32)
        else $error("more than thirty-two bits in a frame");
endmodule : ptspi_checker

`default_nettype wire

// >>> testbench/testbench.sv
// Purpose: drives both ends of the readout link and judges each frame that is not cut short by reset
// Assumes: link clock made by the master at 800 kHz from the system clock
// Notes:   bits are captured off the wire on rising link clock edges
`timescale 1ns/10ps
`default_nettype none

module testbench;
    localparam int LIMIT = 40000;   // well above the five frames run
    logic        clk_sys;
    logic        rst_n;
    logic [15:0] press;
    logic [15:0] temp;
    logic        valid;
    logic        start;
    logic [1:0]  nbytes;
    logic        s_busy;
    logic        s_fresh;
    logic [15:0] frames;
    logic        m_busy;
    logic        m_done;
    logic [13:0] m_press;
    logic [10:0] m_temp;
    logic [31:0] cap;
    logic [31:0] exp_word;
    int          ncap;
    int          n_errors;
    int          n_tests;
    int          cyc;

    ptspi_if ptspi_if_inst ();
    ptspi_sensor ptspi_sensor_inst (.I_CLK_SYS(clk_sys), .I_NRST(rst_n),
        .link(ptspi_if_inst.sensor), .I_PRESS(press), .I_TEMP(temp), .I_VALID(valid),
        .O_BUSY(s_busy), .O_FRESH(s_fresh), .O_FRAMES(frames));
    ptspi_master #(.OSC_FAST(1'b1), .SCLK_KHZ(800)) ptspi_master_inst (.I_CLK_SYS(clk_sys),
        .I_NRST(rst_n), .link(ptspi_if_inst.master), .I_START(start), .I_NBYTES(nbytes),
        .O_BUSY(m_busy), .O_DONE(m_done), .O_PRESS(m_press), .O_TEMP(m_temp));
    ptspi_checker ptspi_checker_inst (.I_CLK_SYS(clk_sys), .I_NRST(rst_n),
        .ss_n(ptspi_if_inst.ss_n), .sclk(ptspi_if_inst.sclk), .miso(ptspi_if_inst.miso),
        .miso_oe(ptspi_if_inst.miso_oe), .miso_line(ptspi_if_inst.miso_line));

    // ==========================================================
    // clock, timeout and wire capture
    always #4 clk_sys = ~clk_sys;
    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc == LIMIT)
        begin
            n_errors++;
            test_done();
        end
    end
    // master samples on the rise, so the bench does too
    always @(posedge ptspi_if_inst.sclk)
        if (ptspi_if_inst.ss_n === 1'b0)
        begin
            cap = {cap[30:0], ptspi_if_inst.miso_line};
            ncap++;
        end
    always @(negedge ptspi_if_inst.ss_n)
    begin
        cap = 32'h00000000;
        ncap = 0;
    end

    // ==========================================================
    // shared tasks
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
        n_tests++;
        if (got !== exp)
        begin
            n_errors++;
            $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask : check

    task automatic test_done();
        $display("comparisons %0d, mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : test_done

    // a new sample; codes above full scale saturate
    task automatic load(input logic [15:0] p, input logic [15:0] t);
        logic [15:0] ps;
        logic [15:0] ts;
        ps = (p > ptspi_pkg::PRESS_MAX) ? ptspi_pkg::PRESS_MAX : p;
        ts = (t > ptspi_pkg::TEMP_MAX) ? ptspi_pkg::TEMP_MAX : t;
        exp_word = {2'b00, ps[13:0], ts[10:0], 5'b00000};
        @(posedge clk_sys);
        #1 press = p;
        temp = t;
        valid = 1'b1;
        @(posedge clk_sys);
        #1 valid = 1'b0;
        repeat (4) @(posedge clk_sys);
        check(s_fresh, 1, "fresh flag");
    endtask : load

    // one read of nbits; low five bits of a full read are masked
    task automatic frame(input logic [1:0] nb, input int nbits);
        int          k;
        logic [15:0] f0;
        logic [10:0] t_exp;
        logic [31:0] mask;
        mask = (nbits == 32) ? 32'hFFFFFFE0 : 32'hFFFFFFFF;
        t_exp = (nbits == 32) ? exp_word[15:5] : (nbits == 24) ? {exp_word[15:8], 3'b000} : m_temp;
        f0 = frames;
        k = 0;
        check(ptspi_if_inst.miso_line, 1, "idle line");
        @(posedge clk_sys);
        #1 nbytes = nb;
        start = 1'b1;
        @(posedge clk_sys);
        #1 start = 1'b0;
        repeat (4) @(posedge clk_sys);
        #1 check({m_busy, s_busy}, 2'b11, "busy in frame");
        while (m_done !== 1'b1 && k < 8000)
        begin
            @(negedge clk_sys);
            k++;
        end
        check(k < 8000, 1, "done seen");
        check(32'(ncap), 32'(nbits), "bit count");
        check(cap & mask, (exp_word >> (32 - nbits)) & mask, "wire bits");
        check(m_press, exp_word[29:16], "pressure");
        check(m_temp, t_exp, "temperature");
        repeat (ptspi_pkg::BUS_CYC + 10) @(posedge clk_sys);
        check(frames, f0 + 16'h0001, "frame count");
        check(s_fresh, 0, "fresh cleared");
        check(s_busy, 0, "sensor idle");
    endtask : frame

    // ==========================================================
    // scenarios
    task automatic t_full();
        load(16'h2ABC, 16'h05A3);
        frame(2'd0, 32);
    endtask : t_full

    // reset mid-frame; the next read must restart from bit one
    task automatic t_reset();
        load(16'h1234, 16'h0321);
        @(posedge clk_sys);
        #1 start = 1'b1;
        @(posedge clk_sys);
        #1 start = 1'b0;
        repeat (1500) @(posedge clk_sys);
        #1 rst_n = 1'b0;
        repeat (3) @(posedge clk_sys);
        check(ptspi_if_inst.ss_n, 1, "select in reset");
        check({m_busy, s_busy, ptspi_if_inst.miso_oe}, 0, "idle in reset");
        check(frames, 0, "count in reset");
        #1 rst_n = 1'b1;
    endtask : t_reset

    task automatic t_two();
        load(16'h0000, 16'h0123);
        frame(2'd2, 16);
    endtask : t_two

    task automatic t_three();
        load(16'hFFFF, 16'h0800);
        frame(2'd3, 24);
    endtask : t_three

    // new sample and a second start land mid-frame; neither may disturb it
    task automatic t_freeze();
        load(16'h1357, 16'h0246);
        fork
            frame(2'd1, 32);
            begin
                repeat (1200) @(posedge clk_sys);
                #1 press = 16'h0001;
                temp = 16'h0002;
                valid = 1'b1;
                start = 1'b1;
                @(posedge clk_sys);
                #1 valid = 1'b0;
                start = 1'b0;
            end
        join
    endtask : t_freeze

    initial
    begin
        clk_sys = 1'b0;
        rst_n = 1'b0;
        press = 16'h0000;
        temp = 16'h0000;
        valid = 1'b0;
        start = 1'b0;
        nbytes = 2'd0;
        cap = 32'h00000000;
        ncap = 0;
        n_errors = 0;
        n_tests = 0;
        cyc = 0;
        repeat (12) @(posedge clk_sys);
        #1 rst_n = 1'b1;
        t_full();
        t_reset();
        t_two();
        t_three();
        t_freeze();
        test_done();
    end
endmodule : testbench

`default_nettype wire
